// File: spi_config_port.sv
/*
  Slave side of a four-wire serial configuration port with buffered register readback.
  Assumes an external register file answering reg_rd_o within the same sys_clk cycle on reg_rdata_i,
  and an SPI host driving cs_n_i and sclk_i with sclk_i low while idle.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spi_cfg_defines.svh"

// Notes on behaviour
// - Reads of one to three bytes shift out exactly that many bytes.
// - Streaming reads continue until chip select rises or the stop point.
// - Multi-byte and streaming transfers visit every address, reserved ones too.
// - Read data changes on the falling serial clock edge.
// - Bidirectional mode uses the shared data pin, driven only for read data.
// - Bits 7 and 0 of register zero set route read data to the readback pin.
// - Register 0x004 bit 0 chooses buffer or active values for readback.
// - Each transfer opens with a 16-bit word: read flag, length, 13-bit address.
// - Length code 00/01/10 means one/two/three bytes, 11 means streaming.
// - Only the 16-bit instruction format exists.
// - After reset bits travel most significant first.
// - Bit order chosen in register zero applies without an update.
// - Most-significant-first transfers step the address down after each byte, except 0x000, which goes to 0x232.
// - Least-significant-first transfers step the address up after each byte.
// - Streaming stops once address 0x232 has been transferred.
// - Downward streams run 0x001, 0x000, 0x232, then stop.
// - Addresses 0x000 through 0xB03 are decoded.
// - During a nonvolatile transfer only the status flag answers.
// - Two-wire address is acknowledged only once the nonvolatile transfer ends.
// - Instruction and write bits are captured on the rising edge.
// - Chip select rising mid-byte aborts and discards the partial byte.
// - Writes except to register zero land in a buffer; self-clearing 0x232 bit 0 activates them.
// - Chip select high at a byte boundary stalls a short transfer.
module spi_config_port
  import spi_cfg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdio_i,
  input wire logic eeprom_busy_i,
  input wire logic [7:0] reg_rdata_i,
  output logic sdio_o,
  output logic sdio_oe_n_o,
  output logic serial_readback_pin_o,
  output logic serial_readback_oe_n_o,
  output logic [`ADDR_W-1:0] reg_addr_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_update_o,
  output logic reg_rd_active_o,
  output logic i2c_addr_ack_o
);

  localparam link_state_t LINK_RESET = '{
    phase: PH_INSTR, bit_cnt: `BIT_CNT_ZERO, shift: '0, is_read: 1'b0, stream: 1'b0,
    bytes_left: 2'h0, cur_addr: '0, lsb: 1'b0, port_lsb: 1'b0, port_uni: 1'b0,
    rd_tgl: 1'b0, rd_addr: '0, wr_tgl: 1'b0, wr_addr: '0, wr_data: `BYTE_ZERO, cs_seen: 1'b0};
  localparam tx_state_t TX_IDLE = '{tx: `BYTE_ZERO, bit_out: 1'b0, sdio_oe_n: 1'b1, pin_oe_n: 1'b1};
  localparam sys_state_t SYS_RESET = '{
    link_rst_n: 1'b0, rd_seen: 1'b0, wr_seen: 1'b0, rd_fetch: 1'b0, reg_addr: '0, reg_rd: 1'b0,
    reg_wr: 1'b0, reg_wdata: `BYTE_ZERO, reg_update: 1'b0, cfg0: `CFG0_RESET, sel_buf: 1'b0,
    sel_act: 1'b0, rd_word: `BYTE_ZERO, addr_ack: 1'b0};

  link_state_t st;
  link_state_t base;
  link_state_t next_st;
  tx_state_t tx;
  tx_state_t next_tx;
  sys_state_t s;
  sys_state_t next_s;
  logic cs_end_tgl;
  logic restart;
  logic last;
  logic [`INSTR_W-1:0] shifted;
  logic [7:0] rx_byte;
  logic [`ADDR_W-1:0] step;
  logic [1:0] tgl_sync;
  logic rd_new;
  logic wr_new;
  logic [7:0] src;
  logic [2:0] idx;
  logic drive;
  logic pin_mask;

  function automatic logic [`ADDR_W-1:0] step_addr(input logic [`ADDR_W-1:0] a, input logic up);
    if (up) begin
      step_addr = a + `ADDR_W'(1);
    end else if (a == `REG_CFG0_ADDR) begin
      step_addr = `STREAM_STOP_ADDR;
    end else begin
      step_addr = a - `ADDR_W'(1);
    end
  endfunction : step_addr

  // Chip select rise: ends the frame unless it falls on a byte boundary of the instruction or of a short transfer's data
  always_ff @(posedge cs_n_i or negedge s.link_rst_n) begin
    if (!s.link_rst_n) begin
      cs_end_tgl <= 1'b0;
    end else if (st.bit_cnt[2:0] != 3'h0 || st.phase == PH_DONE || st.stream) begin
      cs_end_tgl <= ~cs_end_tgl;
    end
  end

  // Serial clock rising edge: instruction decode, write capture, address stepping
  always_comb begin
    base = st;
    restart = (cs_end_tgl != st.cs_seen);
    if (restart) begin
      base.phase = PH_INSTR;
      base.bit_cnt = `BIT_CNT_ZERO;
      base.stream = 1'b0;
      base.lsb = st.port_lsb;
      base.cs_seen = cs_end_tgl;
    end
    shifted = base.lsb ? {sdio_i, base.shift[`INSTR_W-1:1]} : {base.shift[`INSTR_W-2:0], sdio_i};
    rx_byte = base.lsb ? shifted[15:8] : shifted[7:0];
    step = step_addr(base.cur_addr, base.lsb);
    last = base.stream ? (base.cur_addr == `STREAM_STOP_ADDR) : (base.bytes_left == 2'h0);
    next_st = base;
    case (base.phase)
      PH_INSTR: begin
        next_st.shift = shifted;
        next_st.bit_cnt = base.bit_cnt + 4'h1;
        if (base.bit_cnt == `INSTR_LAST_BIT) begin
          next_st.phase = PH_DATA;
          next_st.bit_cnt = `BIT_CNT_ZERO;
          next_st.is_read = shifted[`INSTR_RW_BIT];
          next_st.stream = (shifted[`INSTR_LEN_HI:`INSTR_LEN_LO] == `LEN_STREAM);
          next_st.bytes_left = shifted[`INSTR_LEN_HI:`INSTR_LEN_LO];
          next_st.cur_addr = shifted[`ADDR_W-1:0];
          if (shifted[`INSTR_RW_BIT]) begin
            next_st.rd_tgl = ~base.rd_tgl;
            next_st.rd_addr = shifted[`ADDR_W-1:0];
          end
        end
      end
      PH_DATA: begin
        next_st.shift = shifted;
        next_st.bit_cnt = base.bit_cnt + 4'h1;
        if (base.bit_cnt == `BIT_CNT_ZERO && base.is_read && !last) begin
          next_st.rd_tgl = ~base.rd_tgl;
          next_st.rd_addr = step;
        end
        if (base.bit_cnt == `BYTE_LAST_BIT) begin
          next_st.bit_cnt = `BIT_CNT_ZERO;
          if (!base.is_read) begin
            next_st.wr_tgl = ~base.wr_tgl;
            next_st.wr_addr = base.cur_addr;
            next_st.wr_data = rx_byte;
            if (base.cur_addr == `REG_CFG0_ADDR) begin
              next_st.port_lsb = rx_byte[`CFG0_LSB_HI] & rx_byte[`CFG0_LSB_LO];
              next_st.port_uni = rx_byte[`CFG0_UNI_HI] & rx_byte[`CFG0_UNI_LO];
            end
          end
          if (last) begin
            next_st.phase = PH_DONE;
          end else begin
            next_st.cur_addr = step;
            if (!base.stream) begin
              next_st.bytes_left = base.bytes_left - 2'h1;
            end
          end
        end
      end
      PH_DONE: begin
        next_st.phase = PH_DONE;
      end
      default: begin
        next_st.phase = PH_DONE;
      end
    endcase
  end

  always_ff @(posedge sclk_i or negedge s.link_rst_n) begin
    if (!s.link_rst_n) begin
      st <= LINK_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Serial clock falling edge: read data onto the selected pin
  always_comb begin
    next_tx = tx;
    drive = (st.phase == PH_DATA) && st.is_read;
    src = (st.bit_cnt == `BIT_CNT_ZERO) ? s.rd_word : tx.tx;
    idx = st.lsb ? st.bit_cnt[2:0] : 3'h7 - st.bit_cnt[2:0];
    next_tx.sdio_oe_n = !(drive && !st.port_uni);
    next_tx.pin_oe_n = !(drive && st.port_uni);
    if (drive) begin
      next_tx.tx = src;
      next_tx.bit_out = src[idx];
    end
  end

  always_ff @(negedge sclk_i or negedge s.link_rst_n) begin
    if (!s.link_rst_n) begin
      tx <= TX_IDLE;
    end else begin
      tx <= next_tx;
    end
  end

  // Pins released while deselected or before a new frame decodes; a byte-boundary stall keeps the bit
  assign pin_mask = cs_n_i || restart || (st.phase == PH_INSTR);

  // System clock side: request crossing, register access, buffer and status
  bit_sync #(
    .WIDTH(2)
  ) u_tgl_sync (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({st.wr_tgl, st.rd_tgl}),
    .q_o(tgl_sync)
  );

  always_comb begin
    next_s = s;
    next_s.link_rst_n = 1'b1;
    next_s.reg_rd = 1'b0;
    next_s.reg_wr = 1'b0;
    next_s.reg_update = 1'b0;
    next_s.rd_fetch = 1'b0;
    next_s.addr_ack = !eeprom_busy_i;
    rd_new = (tgl_sync[0] != s.rd_seen);
    wr_new = (tgl_sync[1] != s.wr_seen);
    if (rd_new) begin
      next_s.rd_seen = tgl_sync[0];
      next_s.reg_addr = st.rd_addr;
      next_s.reg_rd = 1'b1;
      next_s.rd_fetch = 1'b1;
    end
    if (s.rd_fetch) begin
      if (s.reg_addr == `REG_STATUS_ADDR) begin
        next_s.rd_word = {7'h00, eeprom_busy_i};
      end else if (eeprom_busy_i || s.reg_addr > `REG_LAST_ADDR) begin
        next_s.rd_word = `BYTE_ZERO;
      end else begin
        case (s.reg_addr)
          `REG_CFG0_ADDR: next_s.rd_word = s.cfg0;
          `REG_READSEL_ADDR: next_s.rd_word = {7'h00, s.sel_buf};
          `REG_UPDATE_ADDR: next_s.rd_word = `BYTE_ZERO;
          default: next_s.rd_word = reg_rdata_i;
        endcase
      end
    end
    if (wr_new) begin
      next_s.wr_seen = tgl_sync[1];
      if (!eeprom_busy_i && st.wr_addr <= `REG_LAST_ADDR) begin
        case (st.wr_addr)
          `REG_CFG0_ADDR: next_s.cfg0 = st.wr_data;
          `REG_READSEL_ADDR: next_s.sel_buf = st.wr_data[`READSEL_BIT];
          `REG_UPDATE_ADDR: begin
            if (st.wr_data[`UPDATE_BIT]) begin
              next_s.reg_update = 1'b1;
              next_s.sel_act = s.sel_buf;
            end
          end
          `REG_STATUS_ADDR: next_s.reg_wr = 1'b0;
          default: begin
            next_s.reg_wr = 1'b1;
            next_s.reg_addr = st.wr_addr;
            next_s.reg_wdata = st.wr_data;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s <= SYS_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign sdio_o = tx.bit_out;
  assign sdio_oe_n_o = tx.sdio_oe_n | pin_mask;
  assign serial_readback_pin_o = tx.bit_out;
  assign serial_readback_oe_n_o = tx.pin_oe_n | pin_mask;
  assign reg_addr_o = s.reg_addr;
  assign reg_rd_o = s.reg_rd;
  assign reg_wr_o = s.reg_wr;
  assign reg_wdata_o = s.reg_wdata;
  assign reg_update_o = s.reg_update;
  assign reg_rd_active_o = s.sel_act;
  assign i2c_addr_ack_o = s.addr_ack;

  property p_decode;
    @(posedge sclk_i) disable iff (!s.link_rst_n)
      (base.phase == PH_INSTR && base.bit_cnt == `INSTR_LAST_BIT)
      |=> (st.phase == PH_DATA && st.cur_addr == $past(shifted[12:0]) && st.is_read == $past(shifted[15]));
  endproperty
  a_decode: assert property (p_decode) else $error("instruction word decoded wrongly");

  property p_len;
    @(posedge sclk_i) disable iff (!s.link_rst_n)
      (base.phase == PH_INSTR && base.bit_cnt == `INSTR_LAST_BIT)
      |=> (st.stream == ($past(shifted[14:13]) == 2'h3)) && (st.stream || st.bytes_left == $past(shifted[14:13]));
  endproperty
  a_len: assert property (p_len) else $error("length code misread");

  property p_rd_req;
    @(posedge sclk_i) disable iff (!s.link_rst_n)
      (base.phase == PH_INSTR && base.bit_cnt == `INSTR_LAST_BIT && shifted[15])
      |=> (st.rd_tgl != $past(st.rd_tgl)) && (st.rd_addr == $past(shifted[12:0]));
  endproperty
  a_rd_req: assert property (p_rd_req) else $error("first read byte not requested");

  property p_dec;
    @(posedge sclk_i) disable iff (!s.link_rst_n)
      (base.phase == PH_DATA && base.bit_cnt == 4'h7 && !last && !base.lsb && base.cur_addr != 13'h000)
      |=> st.cur_addr == $past(base.cur_addr) - 13'h001;
  endproperty
  a_dec: assert property (p_dec) else $error("address did not step down");

  property p_inc;
    @(posedge sclk_i) disable iff (!s.link_rst_n)
      (base.phase == PH_DATA && base.bit_cnt == 4'h7 && !last && base.lsb)
      |=> st.cur_addr == $past(base.cur_addr) + 13'h001;
  endproperty
  a_inc: assert property (p_inc) else $error("address did not step up");

  property p_wrap;
    @(posedge sclk_i) disable iff (!s.link_rst_n)
      (base.phase == PH_DATA && base.bit_cnt == 4'h7 && !last && !base.lsb && base.cur_addr == 13'h000)
      |=> st.cur_addr == 13'h232;
  endproperty
  a_wrap: assert property (p_wrap) else $error("downward stream did not wrap");

  property p_stop;
    @(posedge sclk_i) disable iff (!s.link_rst_n)
      (base.phase == PH_DATA && base.bit_cnt == 4'h7 && base.stream && base.cur_addr == 13'h232)
      |=> st.phase == PH_DONE;
  endproperty
  a_stop: assert property (p_stop) else $error("stream ran past stop address");

  property p_quiet;
    @(posedge sclk_i) disable iff (!s.link_rst_n)
      (st.phase != PH_DATA) |-> (sdio_oe_n_o && serial_readback_oe_n_o);
  endproperty
  a_quiet: assert property (p_quiet) else $error("data pin driven outside read data");

  property p_busy;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (wr_new && eeprom_busy_i) |=> (!reg_wr_o && !reg_update_o);
  endproperty
  a_busy: assert property (p_busy) else $error("write passed while busy");

  property p_update;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (wr_new && !eeprom_busy_i && st.wr_addr == 13'h232 && st.wr_data[0]) |=> reg_update_o ##1 !reg_update_o;
  endproperty
  a_update: assert property (p_update) else $error("update not a single pulse");

  property p_status;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (s.rd_fetch && s.reg_addr == 13'hB00) |=> s.rd_word == {7'h00, $past(eeprom_busy_i)};
  endproperty
  a_status: assert property (p_status) else $error("status read wrong");

endmodule : spi_config_port

`default_nettype wire

// File: spi_cfg_defines.svh
/*
  Register offsets, field positions, reset values and codes of the serial configuration port.
  Assumes inclusion by its bare name from the package and the design files.
*/
`ifndef SPI_CFG_DEFINES_SVH
`define SPI_CFG_DEFINES_SVH

`define ADDR_W 13
`define INSTR_W 16
`define REG_CFG0_ADDR 13'h000
`define REG_READSEL_ADDR 13'h004
`define REG_UPDATE_ADDR 13'h232
`define REG_STATUS_ADDR 13'hB00
`define REG_LAST_ADDR 13'hB03
`define STREAM_STOP_ADDR 13'h232
`define CFG0_RESET 8'h18
`define CFG0_UNI_HI 7
`define CFG0_UNI_LO 0
`define CFG0_LSB_HI 6
`define CFG0_LSB_LO 1
`define READSEL_BIT 0
`define UPDATE_BIT 0
`define INSTR_RW_BIT 15
`define INSTR_LEN_HI 14
`define INSTR_LEN_LO 13
`define LEN_STREAM 2'h3
`define INSTR_LAST_BIT 4'hF
`define BYTE_LAST_BIT 4'h7
`define BIT_CNT_ZERO 4'h0
`define BYTE_ZERO 8'h00

`endif

// File: spi_cfg_pkg.sv
/*
  Types of the serial configuration port: link phase and the state records of each clock domain.
  Assumes spi_cfg_defines.svh is on the include path.
*/
`include "spi_cfg_defines.svh"

package spi_cfg_pkg;

  typedef enum logic [1:0] {
    PH_INSTR = 2'b00,
    PH_DATA = 2'b01,
    PH_DONE = 2'b10
  } link_phase_t;

  typedef struct packed {
    link_phase_t phase;
    logic [3:0] bit_cnt;
    logic [`INSTR_W-1:0] shift;
    logic is_read;
    logic stream;
    logic [1:0] bytes_left;
    logic [`ADDR_W-1:0] cur_addr;
    logic lsb;
    logic port_lsb;
    logic port_uni;
    logic rd_tgl;
    logic [`ADDR_W-1:0] rd_addr;
    logic wr_tgl;
    logic [`ADDR_W-1:0] wr_addr;
    logic [7:0] wr_data;
    logic cs_seen;
  } link_state_t;

  typedef struct packed {
    logic [7:0] tx;
    logic bit_out;
    logic sdio_oe_n;
    logic pin_oe_n;
  } tx_state_t;

  typedef struct packed {
    logic link_rst_n;
    logic rd_seen;
    logic wr_seen;
    logic rd_fetch;
    logic [`ADDR_W-1:0] reg_addr;
    logic reg_rd;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic reg_update;
    logic [7:0] cfg0;
    logic sel_buf;
    logic sel_act;
    logic [7:0] rd_word;
    logic addr_ack;
  } sys_state_t;

endpackage : spi_cfg_pkg

// File: bit_sync.sv
/*
  Two-flop level synchroniser for a group of independent toggle bits.
  Assumes each input bit changes at most once per several destination clock edges.
*/
`timescale 1ns/10ps
`default_nettype none

module bit_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  if (WIDTH < 1) begin : g_bad_width
    $error("bit_sync needs at least one bit");
  end

  always_comb begin
    next_s.meta = d_i;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.stable;

endmodule : bit_sync

`default_nettype wire

// File: reg_file_model.sv
/*
  External register file model facing the configuration port's register side.
  Assumes reg_rd_i is a one-cycle pulse and the port samples reg_rdata_o at the clock edge that ends the pulse.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spi_cfg_defines.svh"

module reg_file_model (
  input wire logic sys_clk_i,
  input wire logic [`ADDR_W-1:0] reg_addr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o
);
  logic [7:0] filler = 8'h00;
  // Valid only while the read strobe stands, otherwise a changing pattern
  always @(posedge sys_clk_i) begin
    filler <= ~filler;
  end
  assign reg_rdata_o = reg_rd_i ? (reg_addr_i[7:0] ^ 8'h5A) : filler;
endmodule : reg_file_model

`default_nettype wire

// File: testbench.sv
/*
  Self-checking bench: acts as the serial host and checks readback, writes and pin use.
  Assumes the register file model returns address low byte xor 0x5A.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spi_cfg_defines.svh"

module testbench
  import spi_cfg_pkg::*;
;
  logic sys_clk = 0, rst_n = 0, sclk = 0, cs_n = 1, host_sdio = 0, busy = 0;
  logic sdio_o, sdio_oe_n, ro, ro_oe_n, reg_rd, reg_wr, reg_upd, rd_act, ack;
  logic [`ADDR_W-1:0] reg_addr, wr_a;
  logic [7:0] wdata, wr_d, rdata;
  logic [7:0] tx [4];
  logic [7:0] rx [4];
  logic drv [4];
  logic uni = 0, lsb = 0;
  int error_cnt = 0, check_count = 0, wr_cnt = 0, upd_cnt = 0, c0, u0;
  wire logic sdio_w;
  // Shared pin level: the port wins while it drives
  assign sdio_w = (sdio_oe_n === 1'b0) ? sdio_o : host_sdio;

  spi_config_port uut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .sclk_i(sclk), .cs_n_i(cs_n), .sdio_i(sdio_w),
    .eeprom_busy_i(busy), .reg_rdata_i(rdata), .sdio_o(sdio_o), .sdio_oe_n_o(sdio_oe_n),
    .serial_readback_pin_o(ro), .serial_readback_oe_n_o(ro_oe_n), .reg_addr_o(reg_addr), .reg_rd_o(reg_rd),
    .reg_wr_o(reg_wr), .reg_wdata_o(wdata), .reg_update_o(reg_upd), .reg_rd_active_o(rd_act),
    .i2c_addr_ack_o(ack));
  reg_file_model reg_model (.sys_clk_i(sys_clk), .reg_addr_i(reg_addr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata));

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (reg_wr === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      wr_a <= reg_addr;
      wr_d <= wdata;
    end
    if (reg_upd === 1'b1) begin
      upd_cnt <= upd_cnt + 1;
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  task automatic half;
    repeat (20) @(negedge sys_clk);
  endtask : half

  // One serial clock: data set while low, sampled just after the rising edge
  task automatic bitx(input logic b, output logic r, output logic oe);
    host_sdio = b;
    half();
    sclk = 1;
    r = uni ? ro : sdio_o;
    oe = uni ? ro_oe_n : sdio_oe_n;
    chk(uni ? sdio_oe_n : ro_oe_n, 1'b1);
    half();
    sclk = 0;
  endtask : bitx

  task automatic frame(input logic rw, input logic [1:0] len, input logic [12:0] a, input int nbit, input int stall);
    logic [15:0] w;
    logic r, oe;
    int i, j;
    w = {rw, len, a};
    cs_n = 0;
    half();
    for (i = 0; i < 16; i++) begin
      bitx(w[lsb ? i : 15 - i], r, oe);
      chk(oe, 1'b1);
    end
    if (stall != 0) begin
      cs_n = 1;
      repeat (60) @(negedge sys_clk);
      cs_n = 0;
      half();
    end
    for (i = 0; i < nbit; i++) begin
      j = lsb ? i % 8 : 7 - i % 8;
      bitx(tx[i / 8][j], r, oe);
      rx[i / 8][j] = r;
      if (i % 8 == 0) begin
        drv[i / 8] = oe;
      end
    end
    cs_n = 1;
    host_sdio = 0;
    repeat (50) @(negedge sys_clk);
  endtask : frame

  initial begin
    #360000;
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (5) @(negedge sys_clk);
    rst_n = 1;
    repeat (10) @(negedge sys_clk);
    chk(sdio_oe_n, 1'b1);
    chk(ro_oe_n, 1'b1);
    frame(1, 2'h0, 13'h010, 8, 0);
    chk(rx[0], 8'h4A);
    chk(drv[0], 1'b0);
    frame(1, 2'h2, 13'h012, 24, 1);
    chk(rx[0], 8'h48);
    chk(rx[1], 8'h4B);
    chk(rx[2], 8'h4A);
    chk(drv[0], 1'b0);
    frame(1, 2'h3, 13'h001, 32, 0);
    chk(rx[0], 8'h5B);
    chk(rx[1], `CFG0_RESET);
    chk(rx[2], 8'h00);
    chk(drv[3], 1'b1);
    tx[0] = 8'h3C;
    tx[1] = 8'hC3;
    c0 = wr_cnt;
    frame(0, 2'h1, 13'h011, 16, 0);
    chk(wr_cnt - c0, 2);
    chk(wr_a, 13'h010);
    chk(wr_d, 8'hC3);
    tx[0] = 8'h77;
    frame(0, 2'h0, 13'h010, 4, 0);
    chk(wr_cnt - c0, 2);
    frame(1, 2'h0, 13'h010, 8, 0);
    chk(rx[0], 8'h4A);
    tx[0] = 8'hC3;
    frame(0, 2'h0, 13'h000, 8, 0);
    lsb = 1;
    uni = 1;
    frame(1, 2'h3, 13'h230, 32, 0);
    chk(rx[0], 8'h6A);
    chk(rx[1], 8'h6B);
    chk(rx[2], 8'h00);
    chk(drv[0], 1'b0);
    chk(drv[3], 1'b1);
    tx[0] = `CFG0_RESET;
    frame(0, 2'h0, 13'h000, 8, 0);
    lsb = 0;
    uni = 0;
    tx[0] = 8'h01;
    frame(0, 2'h0, 13'h004, 8, 0);
    chk(rd_act, 1'b0);
    u0 = upd_cnt;
    frame(0, 2'h0, 13'h232, 8, 0);
    chk(upd_cnt - u0, 1);
    chk(rd_act, 1'b1);
    chk(wr_cnt - c0, 2);
    busy = 1;
    repeat (4) @(negedge sys_clk);
    chk(ack, 1'b0);
    frame(1, 2'h0, 13'hB00, 8, 0);
    chk(rx[0], 8'h01);
    frame(1, 2'h0, 13'h010, 8, 0);
    chk(rx[0], 8'h00);
    tx[0] = 8'h99;
    frame(0, 2'h0, 13'h010, 8, 0);
    chk(16'(wr_cnt - c0), 16'h0002);
    busy = 0;
    repeat (4) @(negedge sys_clk);
    chk(ack, 1'b1);
    frame(1, 2'h0, 13'hB00, 8, 0);
    chk(rx[0], 8'h00);
    frame(1, 2'h0, 13'h1005, 8, 0);
    chk(rx[0], 8'h00);
    frame(1, 2'h0, 13'hB01, 8, 0);
    chk(rx[0], 8'h5B);
    end_sim();
  end
endmodule : testbench

`default_nettype wire
